// ===== logic/strs_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module strs_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	// fill side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// drain side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;
	assign in_ready_out  = (count != (AW+1)'(DEPTH));
	assign out_valid_out = (count != '0);
	assign out_data_out  = mem[rd_ptr];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : strs_fifo
`default_nettype wire

// ===== logic/strs_sampler.sv
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - the two delay bits shift sampling by 0, 3 or 6 sample ticks (520 ns and 910 ns rounded down to ticks).
// - test bit set with prefilter bit clear disables all layer-1 receive work.
// - majority oversampling runs only in terminal and trunk terminal modes.
// - each bit window takes 29 samples spaced at the 7.68 MHz sampling tick.
// - 16 or more samples above threshold give a zero, otherwise a one.
// - the receiver switches between two sensitivity levels, picking the threshold.
// - in terminal power-down only level detection runs and all clocks stop.
// - while powered down, serial data outputs sit high and clock outputs low.
// - line activation seen during power-down restarts the clocks on its own.
// - a 192 kbit/s line bit spans forty sampling clock cycles.
module strs_sampler #(
	parameter int FIFO_DEPTH = 16,
	parameter int LEVEL_BITS = 8
) (
	// clock and reset
	input  wire logic                  MCLK_IN,
	input  wire logic                  SYS_RST_IN,
	// register port
	input  wire logic [3:0]            ADDR_IN,
	input  wire logic [7:0]            WDATA_IN,
	input  wire logic                  WR_IN,
	input  wire logic                  RD_IN,
	output logic      [7:0]            RDATA_OUT,
	// line side
	input  wire logic [LEVEL_BITS-1:0] LINE_LEVEL_IN,
	input  wire logic                  LINE_ACT_IN,
	// received bit stream
	output logic                       RX_VALID_OUT,
	input  wire logic                  RX_READY_IN,
	output logic                       RX_BIT_OUT,
	// system serial port
	output logic                       SER_CLK_OUT,
	output logic                       SER_DATA_OUT,
	output logic                       POWERED_DOWN_OUT
);
	// phase accumulator makes the 7.68 MHz tick from the 20 MHz clock
	localparam logic [15:0] PH_STEP = 16'(strs_pkg::SAMPLE_CLK_HZ / 1000);
	localparam logic [15:0] PH_MOD  = 16'(strs_pkg::CLK_HZ / 1000);
	localparam int          WIN     = strs_pkg::BIT_WINDOW_CYCLES;
	localparam int          WIN_W   = $clog2(WIN);

	logic [7:0]            aux_config_one;
	logic [7:0]            serial_port_control_reg;
	logic [1:0]            mode_reg;
	logic [LEVEL_BITS-1:0] receive_threshold_a;
	logic [LEVEL_BITS-1:0] receive_threshold_b;
	logic [LEVEL_BITS-1:0] level_s1;
	logic [LEVEL_BITS-1:0] level_s2;
	logic                  act_s1;
	logic                  act_s2;
	logic [15:0]           phase;
	logic                  tick;
	logic [WIN_W-1:0]      win_cnt;
	logic [3:0]            delay_cnt;
	logic [4:0]            sample_cnt;
	logic [4:0]            above_cnt;
	logic                  high_sens;
	logic                  spu_prev;
	logic                  spu_armed;
	strs_pkg::strs_pwr_t   pwr;
	logic                  fifo_in_valid;
	logic                  fifo_in_ready;
	logic                  fifo_out_valid;
	logic                  fifo_out_data;
	logic                  decided;
	logic [2:0]            ser_div;

	logic       prefilter_delay_select;
	logic       layer1_test_select;
	logic       software_power_up;
	logic       layer1_off;
	logic       oversample_on;
	logic       terminal_mode;
	logic       trunk_terminal_mode;
	logic       clocks_run;
	logic [3:0] delay_ticks;
	logic [LEVEL_BITS-1:0] threshold;

	assign prefilter_delay_select = aux_config_one[strs_pkg::AUX_PFS_BIT];
	assign layer1_test_select     = aux_config_one[strs_pkg::AUX_TEM_BIT];
	assign software_power_up      = serial_port_control_reg[strs_pkg::SPC_SPU_BIT];
	assign terminal_mode          = (mode_reg == strs_pkg::STRS_MODE_TE);
	assign trunk_terminal_mode    = (mode_reg == strs_pkg::STRS_MODE_LTT);
	assign layer1_off             = layer1_test_select && !prefilter_delay_select;
	assign oversample_on          = (terminal_mode || trunk_terminal_mode) && !layer1_off;
	// wake restarts clocks at once; software only has to drop the request afterwards
	assign clocks_run             = (pwr != strs_pkg::STRS_PWR_DOWN);
	assign threshold = high_sens ? receive_threshold_a : receive_threshold_b;

	always_comb begin
		delay_ticks = 4'h0;
		if (prefilter_delay_select) begin
			delay_ticks = layer1_test_select ? 4'(strs_pkg::DELAY_PF_TEM_TICKS)
			                                 : 4'(strs_pkg::DELAY_PF_TICKS);
		end
	end

	// registers
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			aux_config_one          <= strs_pkg::AUX_CONFIG_ONE_RST;
			serial_port_control_reg <= strs_pkg::SERIAL_PORT_RST;
			mode_reg                <= strs_pkg::MODE_RST;
			receive_threshold_a     <= LEVEL_BITS'(strs_pkg::THRESHOLD_RST);
			receive_threshold_b     <= LEVEL_BITS'(strs_pkg::THRESHOLD_RST);
		end else if (WR_IN) begin
			unique case (ADDR_IN)
				strs_pkg::ADDR_AUX_CONFIG_ONE:   aux_config_one <= WDATA_IN;
				strs_pkg::ADDR_SERIAL_PORT_CTRL: serial_port_control_reg <= WDATA_IN;
				strs_pkg::ADDR_MODE:             mode_reg <= WDATA_IN[1:0];
				strs_pkg::ADDR_THRESHOLD_A:      receive_threshold_a <= LEVEL_BITS'(WDATA_IN);
				strs_pkg::ADDR_THRESHOLD_B:      receive_threshold_b <= LEVEL_BITS'(WDATA_IN);
				default: ;
			endcase
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			RDATA_OUT <= 8'h00;
		end else if (RD_IN) begin
			unique case (ADDR_IN)
				strs_pkg::ADDR_AUX_CONFIG_ONE:   RDATA_OUT <= aux_config_one;
				strs_pkg::ADDR_SERIAL_PORT_CTRL: RDATA_OUT <= serial_port_control_reg;
				strs_pkg::ADDR_MODE:             RDATA_OUT <= {6'h00, mode_reg};
				strs_pkg::ADDR_STATUS: begin
					RDATA_OUT <= {3'h0, high_sens, layer1_off, oversample_on, pwr};
				end
				strs_pkg::ADDR_RX_DATA: RDATA_OUT <= {7'h00, decided};
				strs_pkg::ADDR_THRESHOLD_A: RDATA_OUT <= 8'(receive_threshold_a);
				strs_pkg::ADDR_THRESHOLD_B: RDATA_OUT <= 8'(receive_threshold_b);
				default: RDATA_OUT <= 8'h00;
			endcase
		end else begin
			RDATA_OUT <= 8'h00;
		end
	end

	// pin synchronisers
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			level_s1 <= '0;
			level_s2 <= '0;
			act_s1   <= 1'b0;
			act_s2   <= 1'b0;
		end else begin
			level_s1 <= LINE_LEVEL_IN;
			level_s2 <= level_s1;
			act_s1   <= LINE_ACT_IN;
			act_s2   <= act_s1;
		end
	end

	// power state: level detect alone keeps running while down
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			pwr       <= strs_pkg::STRS_PWR_UP;
			spu_prev  <= 1'b0;
			spu_armed <= 1'b0;
		end else begin
			spu_prev <= software_power_up;
			if (software_power_up && !spu_prev) begin
				spu_armed <= 1'b1;
			end
			unique case (pwr)
				strs_pkg::STRS_PWR_UP: begin
					spu_armed <= 1'b0;
					if (serial_port_control_reg[strs_pkg::SPC_PD_BIT] && terminal_mode) begin
						pwr <= strs_pkg::STRS_PWR_DOWN;
					end
				end
				strs_pkg::STRS_PWR_DOWN: begin
					if (act_s2) begin
						pwr <= strs_pkg::STRS_PWR_WAKE;
					end else if (spu_armed && !software_power_up) begin
						pwr <= strs_pkg::STRS_PWR_WAKE;
					end
				end
				strs_pkg::STRS_PWR_WAKE: begin
					// power-down request must drop before settling; until then the state holds in wake
					if (!serial_port_control_reg[strs_pkg::SPC_PD_BIT]) begin
						pwr <= strs_pkg::STRS_PWR_UP;
					end
				end
				default: pwr <= strs_pkg::STRS_PWR_UP;
			endcase
		end
	end

	// sample tick generator, stopped while clocks are off
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN || !clocks_run || layer1_off) begin
			phase <= 16'h0000;
			tick  <= 1'b0;
		end else if (phase + PH_STEP >= PH_MOD) begin
			phase <= phase + PH_STEP - PH_MOD;
			tick  <= 1'b1;
		end else begin
			phase <= phase + PH_STEP;
			tick  <= 1'b0;
		end
	end

	// bit window: forty ticks, delay then 29 samples
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN || !clocks_run || layer1_off) begin
			win_cnt    <= '0;
			delay_cnt  <= 4'h0;
			sample_cnt <= 5'h00;
			above_cnt  <= 5'h00;
		end else if (tick) begin
			if (win_cnt == WIN_W'(WIN - 1)) begin
				win_cnt    <= '0;
				delay_cnt  <= 4'h0;
				sample_cnt <= 5'h00;
				above_cnt  <= 5'h00;
			end else begin
				win_cnt <= win_cnt + 1'b1;
				if (delay_cnt != delay_ticks) begin
					delay_cnt <= delay_cnt + 1'b1;
				end else if (sample_cnt != 5'(strs_pkg::SAMPLES_PER_BIT)) begin
					sample_cnt <= sample_cnt + 1'b1;
					if (level_s2 > threshold) begin
						above_cnt <= above_cnt + 1'b1;
					end
				end
			end
		end
	end

	// decision and sensitivity switch at window end
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			decided       <= 1'b1;
			fifo_in_valid <= 1'b0;
			high_sens     <= 1'b1;
		end else begin
			fifo_in_valid <= 1'b0;
			if (tick && clocks_run && !layer1_off && win_cnt == WIN_W'(WIN - 1)) begin
				if (oversample_on) begin
					decided <= !(above_cnt >= 5'(strs_pkg::MAJORITY_THRESHOLD));
				end else begin
					decided <= !(level_s2 > threshold);
				end
				// strong pulse drops sensitivity, a quiet window raises it
				high_sens     <= !(level_s2 > receive_threshold_b);
				fifo_in_valid <= fifo_in_ready; // a full queue drops the bit
			end
		end
	end

	strs_fifo #(
		.WIDTH(1),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_in       (MCLK_IN),
		.rst_in       (SYS_RST_IN),
		.in_valid_in  (fifo_in_valid),
		.in_ready_out (fifo_in_ready),
		.in_data_in   (decided),
		.out_valid_out(fifo_out_valid),
		.out_ready_in (clocks_run && RX_READY_IN && !RX_VALID_OUT),
		.out_data_out (fifo_out_data)
	);

	// output stage from flip-flops
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			RX_VALID_OUT <= 1'b0;
			RX_BIT_OUT   <= 1'b1;
		end else if (clocks_run && RX_READY_IN && !RX_VALID_OUT && fifo_out_valid) begin
			// queued bits wait while clocks are stopped
			RX_VALID_OUT <= 1'b1;
			RX_BIT_OUT   <= fifo_out_data;
		end else begin
			RX_VALID_OUT <= 1'b0;
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			ser_div          <= 3'h0;
			SER_CLK_OUT      <= 1'b0;
			SER_DATA_OUT     <= 1'b1;
			POWERED_DOWN_OUT <= 1'b0;
		end else begin
			POWERED_DOWN_OUT <= !clocks_run;
			if (!clocks_run) begin
				ser_div      <= 3'h0;
				SER_CLK_OUT  <= 1'b0;
				SER_DATA_OUT <= 1'b1;
			end else begin
				ser_div      <= ser_div + 1'b1;
				SER_CLK_OUT  <= ser_div[2];
				SER_DATA_OUT <= RX_BIT_OUT;
			end
		end
	end
endmodule : strs_sampler
`default_nettype wire

// ===== pkg/strs_pkg.sv
package strs_pkg;
	// sampling clock and line timing
	localparam int CLK_HZ              = 20000000;
	localparam int SAMPLE_CLK_HZ       = 7680000;
	localparam int LINE_BIT_RATE       = 192000;
	localparam int BIT_WINDOW_CYCLES   = SAMPLE_CLK_HZ / LINE_BIT_RATE;
	localparam int SAMPLES_PER_BIT     = 29;
	localparam int MAJORITY_THRESHOLD  = 16;
	// delay compensation, in ns and in sample clock ticks (rounded down)
	localparam int DELAY_PF_NS         = 520;
	localparam int DELAY_PF_TEM_NS     = 910;
	localparam int DELAY_PF_TICKS      = (DELAY_PF_NS * 768) / 100000;
	localparam int DELAY_PF_TEM_TICKS  = (DELAY_PF_TEM_NS * 768) / 100000;
	// register map (index = byte address)
	localparam logic [3:0] ADDR_AUX_CONFIG_ONE   = 4'h0;
	localparam logic [3:0] ADDR_SERIAL_PORT_CTRL = 4'h1;
	localparam logic [3:0] ADDR_MODE             = 4'h2;
	localparam logic [3:0] ADDR_STATUS           = 4'h3;
	localparam logic [3:0] ADDR_RX_DATA          = 4'h4;
	localparam logic [3:0] ADDR_THRESHOLD_A      = 4'h5;
	localparam logic [3:0] ADDR_THRESHOLD_B      = 4'h6;
	// field positions
	localparam int AUX_PFS_BIT  = 0;
	localparam int AUX_TEM_BIT  = 1;
	localparam int SPC_SPU_BIT  = 0;
	localparam int SPC_PD_BIT   = 1;
	// reset values
	localparam logic [7:0] AUX_CONFIG_ONE_RST = 8'h00;
	localparam logic [7:0] SERIAL_PORT_RST    = 8'h00;
	localparam logic [1:0] MODE_RST           = 2'h0;
	localparam logic [7:0] THRESHOLD_RST      = 8'h00;
	typedef enum logic [1:0] {
		STRS_MODE_NT  = 2'h0,
		STRS_MODE_LTS = 2'h1,
		STRS_MODE_TE  = 2'h2,
		STRS_MODE_LTT = 2'h3
	} strs_mode_t;
	typedef enum logic [1:0] {
		STRS_PWR_UP   = 2'h0,
		STRS_PWR_DOWN = 2'h1,
		STRS_PWR_WAKE = 2'h3
	} strs_pwr_t;
endpackage : strs_pkg

// ===== tb/strs_line_model.sv
`timescale 1ns/100ps
`default_nettype none
module strs_line_model (
	// clock
	input  wire logic       clk_in,
	// bench controls
	input  wire logic       bit_in,
	input  wire logic [2:0] spoil_in,
	input  wire logic [7:0] mark_in,
	input  wire logic       act_in,
	// line side
	output logic      [7:0] level_out,
	output logic            act_out
);
	logic [2:0] phase = 3'h0;
	logic       mark;
	// spoil_in of every eight cycles show the opposite line state: noise the vote must ride out
	assign mark = (phase < spoil_in) ? bit_in : !bit_in;
	always_ff @(posedge clk_in) begin
		phase <= phase + 3'h1;
	end
	// a one is the neutral level, a zero a pulse
	assign level_out = mark ? mark_in : 8'h08;
	assign act_out = act_in;
endmodule // strs_line_model
`default_nettype wire

// ===== tb/strs_sampler_bench.sv
`timescale 1ns/100ps
`default_nettype none
module strs_sampler_bench;
	logic       MCLK_IN = 1'b0, SYS_RST_IN = 1'b1, WR_IN = 1'b0, RD_IN = 1'b0;
	logic       RX_READY_IN = 1'b1, LINE_ACT_IN, RX_VALID_OUT, RX_BIT_OUT;
	logic       SER_CLK_OUT, SER_DATA_OUT, POWERED_DOWN_OUT;
	logic [3:0] ADDR_IN = 4'h0;
	logic [7:0] WDATA_IN = 8'h00, RDATA_OUT, LINE_LEVEL_IN, d, mark_lvl = 8'hC0;
	logic       line_bit = 1'b1, act = 1'b0;
	logic [2:0] spoil = 3'h0;
	int         n_fail = 0, samples_checked = 0, nv, n0, n1;
	always #25 MCLK_IN = !MCLK_IN;
	strs_sampler strs_sampler_i (.MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN), .ADDR_IN(ADDR_IN),
		.WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
		.LINE_LEVEL_IN(LINE_LEVEL_IN), .LINE_ACT_IN(LINE_ACT_IN), .RX_VALID_OUT(RX_VALID_OUT),
		.RX_READY_IN(RX_READY_IN), .RX_BIT_OUT(RX_BIT_OUT), .SER_CLK_OUT(SER_CLK_OUT),
		.SER_DATA_OUT(SER_DATA_OUT), .POWERED_DOWN_OUT(POWERED_DOWN_OUT));
	strs_line_model strs_line_model_i (.clk_in(MCLK_IN), .bit_in(line_bit), .spoil_in(spoil),
		.mark_in(mark_lvl), .act_in(act), .level_out(LINE_LEVEL_IN), .act_out(LINE_ACT_IN));
	task automatic end_of_test;
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge MCLK_IN);
		ADDR_IN <= a;
		WDATA_IN <= v;
		WR_IN <= 1'b1;
		@(posedge MCLK_IN);
		WR_IN <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge MCLK_IN);
		ADDR_IN <= a;
		RD_IN <= 1'b1;
		@(posedge MCLK_IN);
		RD_IN <= 1'b0;
		#1 v = RDATA_OUT;
	endtask
	// counts delivered bits over n windows of 105 cycles
	task automatic bits(input int n);
		nv = 0;
		n0 = 0;
		n1 = 0;
		repeat (n * 105) begin
			@(posedge MCLK_IN);
			#1;
			if (RX_VALID_OUT === 1'b1) begin
				nv++;
				if (RX_BIT_OUT === 1'b0) n0++;
				else n1++;
			end
		end
	endtask
	// the first windows after a change may still carry old bits, so they are skipped
	task automatic stream(input string what, input logic b);
		bits(3);
		bits(8);
		chk({what, " count"}, 8'h01, 8'(nv >= 7 && nv <= 9));
		chk(what, 8'h00, 8'(b ? n0 : n1));
	endtask
	task automatic wait_pd(input logic v);
		int k;
		k = 0;
		#1;
		while (POWERED_DOWN_OUT !== v && k < 200) begin
			@(posedge MCLK_IN);
			#1;
			k++;
		end
		chk("power state", {7'h0, v}, {7'h0, POWERED_DOWN_OUT});
		if (k == 200) end_of_test();
	endtask
	task automatic t_reset;
		@(posedge MCLK_IN);
		#1;
		chk("bit after reset", 8'h01, {7'h0, RX_BIT_OUT});
		chk("data line after reset", 8'h01, {7'h0, SER_DATA_OUT});
		for (int a = 0; a < 3; a++) begin
			rd(4'(a), d);
			chk("register reset value", 8'h00, d);
		end
		wr(4'hF, 8'hFF);
		rd(4'hF, d);
		chk("unmapped read", 8'h00, d);
		rd(4'h0, d);
		chk("config after stray write", 8'h00, d);
	endtask
	task automatic t_modes;
		for (int m = 0; m < 4; m++) begin
			wr(4'h2, 8'(m));
			rd(4'h3, d);
			chk("oversample flag", 8'(m >= 2), {7'h0, d[2]});
		end
	endtask
	task automatic t_major;
		wr(4'h2, 8'h02);
		wr(4'h5, 8'h40);
		wr(4'h6, 8'h40);
		line_bit <= 1'b0;
		spoil <= 3'h3;
		stream("mark with noise", 1'b0);
		line_bit <= 1'b1;
		stream("space with noise", 1'b1);
		line_bit <= 1'b0;
		spoil <= 3'h5;
		stream("mark outvoted", 1'b1);
	endtask
	task automatic t_sense;
		spoil <= 3'h0;
		mark_lvl <= 8'h60;
		wr(4'h5, 8'h70);
		wr(4'h6, 8'h68);
		stream("high sensitivity", 1'b1);
		rd(4'h3, d);
		chk("sensitivity flag", 8'h01, {7'h0, d[4]});
		wr(4'h6, 8'h58);
		stream("low sensitivity", 1'b0);
		rd(4'h3, d);
		chk("sensitivity flag", 8'h00, {7'h0, d[4]});
		mark_lvl <= 8'hC0;
		wr(4'h5, 8'h40);
		wr(4'h6, 8'h40);
	endtask
	task automatic t_delay;
		spoil <= 3'h2;
		for (int i = 0; i < 3; i++) begin
			wr(4'h0, 8'(i == 2 ? 3 : i));
			stream("delayed sampling", 1'b0);
			rd(4'h3, d);
			chk("layer1 off flag", 8'h00, {7'h0, d[3]});
		end
		wr(4'h0, 8'h02);
		rd(4'h3, d);
		chk("layer1 off flag", 8'h01, {7'h0, d[3]});
		bits(3);
		bits(8);
		chk("bits while disabled", 8'h00, nv[7:0]);
		wr(4'h0, 8'h00);
	endtask
	// sixteen bits fit the buffer; later ones are dropped
	task automatic t_fifo;
		bits(2);
		RX_READY_IN <= 1'b0;
		bits(20);
		chk("valid while stalled", 8'h00, nv[7:0]);
		RX_READY_IN <= 1'b1;
		bits(1);
		chk("burst after stall", 8'h01, 8'(nv >= 16 && nv <= 18));
	endtask
	task automatic t_sleep;
		wr(4'h2, 8'h00);
		wr(4'h1, 8'h02);
		repeat (20) @(posedge MCLK_IN);
		#1;
		chk("sleep outside terminal", 8'h00, {7'h0, POWERED_DOWN_OUT});
		wr(4'h2, 8'h02);
		wait_pd(1'b1);
		chk("serial data asleep", 8'h01, {7'h0, SER_DATA_OUT});
		chk("serial clock asleep", 8'h00, {7'h0, SER_CLK_OUT});
		rd(4'h3, d);
		chk("power state code", 8'h01, {6'h0, d[1:0]});
		act <= 1'b1;
		wait_pd(1'b0);
		act <= 1'b0;
		wr(4'h1, 8'h00);
		wr(4'h1, 8'h02);
		wait_pd(1'b1);
		wr(4'h1, 8'h03);
		wr(4'h1, 8'h02);
		wait_pd(1'b0);
		wr(4'h1, 8'h00);
	endtask
	initial begin
		repeat (10) @(posedge MCLK_IN);
		SYS_RST_IN <= 1'b0;
		t_reset();
		t_modes();
		t_major();
		t_sense();
		t_delay();
		t_fifo();
		t_sleep();
		end_of_test();
	end
endmodule // strs_sampler_bench
`default_nettype wire

// ===== tb/strs_sampler_properties.sv
`timescale 1ns/100ps
`default_nettype none
module strs_sampler_properties (
	// clock and reset
	input  wire logic       MCLK_IN,
	input  wire logic       SYS_RST_IN,
	// register port
	input  wire logic [3:0] ADDR_IN,
	input  wire logic       RD_IN,
	input  wire logic [7:0] RDATA_OUT,
	// line and stream
	input  wire logic       LINE_ACT_IN,
	input  wire logic       RX_VALID_OUT,
	input  wire logic       RX_BIT_OUT,
	// serial port
	input  wire logic       SER_CLK_OUT,
	input  wire logic       SER_DATA_OUT,
	input  wire logic       POWERED_DOWN_OUT
);
	logic [3:0] still_cnt;
	logic       last_clk;
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	// a serial clock stuck while up would slip past every edge-based check
	always_ff @(posedge MCLK_IN) begin
		last_clk <= SER_CLK_OUT;
		if (SYS_RST_IN || POWERED_DOWN_OUT || last_clk != SER_CLK_OUT) begin
			still_cnt <= 4'h0;
		end else if (still_cnt != 4'hF) begin
			still_cnt <= still_cnt + 4'h1;
		end
	end
	sleep_levels_a: assert property (POWERED_DOWN_OUT && $past(POWERED_DOWN_OUT) |->
		SER_DATA_OUT && !SER_CLK_OUT) else $error("serial pins wrong while asleep");
	sleep_silent_a: assert property (POWERED_DOWN_OUT && $past(POWERED_DOWN_OUT) |->
		!RX_VALID_OUT) else $error("bit delivered while asleep");
	clock_runs_a: assert property (still_cnt < 4'h7)
		else $error("serial clock stopped while up");
	clock_rate_a: assert property ($changed(SER_CLK_OUT) && !POWERED_DOWN_OUT |=>
		(POWERED_DOWN_OUT || $stable(SER_CLK_OUT)) [*3]) else $error("serial clock too fast");
	line_wake_a: assert property ((POWERED_DOWN_OUT && LINE_ACT_IN) [*3] |->
		##[0:5] !POWERED_DOWN_OUT) else $error("line activation did not wake");
	sleep_status_a: assert property (RD_IN && ADDR_IN == 4'h3 && POWERED_DOWN_OUT ##1
		POWERED_DOWN_OUT |-> RDATA_OUT[1:0] == 2'h1) else $error("status not down");
	valid_pulse_a: assert property (RX_VALID_OUT |=> !RX_VALID_OUT)
		else $error("valid longer than one cycle");
	bit_hold_a: assert property (!RX_VALID_OUT |-> $stable(RX_BIT_OUT))
		else $error("bit changed without valid");
endmodule // strs_sampler_properties
bind strs_sampler strs_sampler_properties strs_sampler_properties_i (
	.MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN), .ADDR_IN(ADDR_IN), .RD_IN(RD_IN),
	.RDATA_OUT(RDATA_OUT), .LINE_ACT_IN(LINE_ACT_IN), .RX_VALID_OUT(RX_VALID_OUT),
	.RX_BIT_OUT(RX_BIT_OUT), .SER_CLK_OUT(SER_CLK_OUT), .SER_DATA_OUT(SER_DATA_OUT),
	.POWERED_DOWN_OUT(POWERED_DOWN_OUT));
`default_nettype wire
